// ==== dbgua_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbgua_baud
  import dbgua_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [15:0] divisor,
  output logic             tick16
);
  // ==========================================================
  // Oversample tick: master clock divided by divisor
  logic [15:0] cnt_q;
  wire         stop_w = (divisor == 16'h0000);
  wire         wrap_w = (cnt_q >= divisor - 16'h0001);
  always_ff @(posedge ref_clk)
  begin
    if (reset || stop_w)
    begin
      cnt_q  <= 16'h0000;
      tick16 <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q  <= wrap_w ? 16'h0000 : cnt_q + 16'h0001;
      tick16 <= wrap_w;
    end
  end
  // Divisor zero keeps the tick silent
  chk_baud_stop: assert property (@(posedge ref_clk) disable iff (reset)
    (divisor == 16'h0000) |=> !tick16)
    else $error("tick while divisor zero");
endmodule : dbgua_baud
`default_nettype wire

// ==== dbgua_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Remote serial terminal
module dbgua_host
  import dbgua_pkg::*;
#(
  parameter int BIT_CLKS = 16
)
(
  input  wire logic ref_clk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // ==========================================================
  // Sender; a low stop is cut short so it cannot pose as a start
  task automatic send(input logic [7:0] d, input logic use_par,
                      input logic par, input logic stop);
    logic [10:0] f;
    int          n;
    f = use_par ? {stop, par, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = use_par ? 11 : 10;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= f[i];
      repeat ((i == n - 1 && !f[i]) ? 10 : BIT_CLKS) @(posedge ref_clk);
    end
    line_out <= 1'b1;
  endtask : send
  task automatic pulse_low(input int n);
    @(posedge ref_clk);
    line_out <= 1'b0;
    repeat (n) @(posedge ref_clk);
    line_out <= 1'b1;
  endtask : pulse_low
  // ==========================================================
  // Receiver; needs data bit 0 high to time the start bit
  task automatic capture(input logic use_par, output logic [7:0] d,
                         output logic par, output logic stop,
                         output int low_len, output logic seen);
    int w;
    w = 0;
    low_len = 0;
    while (line_in !== 1'b0 && w < 6000)
    begin
      @(negedge ref_clk);
      w++;
    end
    seen = (w < 6000);
    while (line_in === 1'b0 && low_len < 40)
    begin
      @(negedge ref_clk);
      low_len++;
    end
    repeat (BIT_CLKS / 2) @(negedge ref_clk);
    d[0] = line_in;
    for (int i = 1; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(negedge ref_clk);
      d[i] = line_in;
    end
    par = 1'b0;
    if (use_par)
    begin
      repeat (BIT_CLKS) @(negedge ref_clk);
      par = line_in;
    end
    repeat (BIT_CLKS) @(negedge ref_clk);
    stop = line_in;
  endtask : capture
endmodule : dbgua_host
`default_nettype wire

// ==== dbgua_pkg.sv ====
package dbgua_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] DBGUA_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DBGUA_MODE_OFS   = 8'h04;
  localparam logic [7:0] DBGUA_STAT_OFS   = 8'h14;
  localparam logic [7:0] DBGUA_RHOLD_OFS  = 8'h18;
  localparam logic [7:0] DBGUA_THOLD_OFS  = 8'h1c;
  localparam logic [7:0] DBGUA_BAUD_OFS   = 8'h20;
  // ==========================================================
  // Control bit positions
  localparam int DBGUA_CR_RX_RESET  = 2;
  localparam int DBGUA_CR_TX_RESET  = 3;
  localparam int DBGUA_CR_RX_EN     = 4;
  localparam int DBGUA_CR_RX_DIS    = 5;
  localparam int DBGUA_CR_TX_EN     = 6;
  localparam int DBGUA_CR_TX_DIS    = 7;
  localparam int DBGUA_CR_STAT_CLR  = 8;
  // ==========================================================
  // Mode field and status bit positions
  localparam int DBGUA_MR_PAR_LSB   = 9;
  localparam int DBGUA_SR_RX_RDY    = 0;
  localparam int DBGUA_SR_TX_FREE   = 1;
  localparam int DBGUA_SR_OVERRUN   = 5;
  localparam int DBGUA_SR_FRAMING   = 6;
  localparam int DBGUA_SR_PAR_ERR   = 7;
  localparam int DBGUA_SR_TX_DONE   = 9;
  // ==========================================================
  // Parity select encodings
  localparam logic [2:0] DBGUA_PAR_EVEN  = 3'h0;
  localparam logic [2:0] DBGUA_PAR_ODD   = 3'h1;
  localparam logic [2:0] DBGUA_PAR_SPACE = 3'h2;
  localparam logic [2:0] DBGUA_PAR_MARK  = 3'h3;
  // ==========================================================
  // Timing in oversample ticks; register reset values and receiver states
  localparam logic [3:0] DBGUA_OVERSAMPLE = 4'hf;
  localparam logic [4:0] DBGUA_START_MIN  = 5'h07;
  localparam logic [4:0] DBGUA_FIRST_SMP  = 5'h18;
  localparam logic [4:0] DBGUA_BIT_SMP    = 5'h10;
  localparam logic [15:0] DBGUA_MODE_RST  = 16'h0000;
  localparam logic [15:0] DBGUA_BAUD_RST  = 16'h0000;
  typedef enum logic [1:0] {DBGUA_IDLE, DBGUA_START, DBGUA_DATA}
    dbgua_rx_t;
endpackage : dbgua_pkg

// ==== dbgua_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbgua_top
  import dbgua_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin
);
  // ==========================================================
  // Parity helper
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [2:0] sel);
    case (sel)
      DBGUA_PAR_EVEN:  par_bit = ^d;
      DBGUA_PAR_ODD:   par_bit = ~^d;
      DBGUA_PAR_SPACE: par_bit = 1'b0;
      DBGUA_PAR_MARK:  par_bit = 1'b1;
      default:         par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // ==========================================================
  // Bus slave: one wait cycle, answer on the second edge
  logic        ack_q;
  logic [2:0]  par_sel_q;
  logic [15:0] baud_divisor_q;
  wire  req_w    = (avs_read || avs_write) && !ack_q;
  wire  wr_w     = avs_write && ack_q && clk_en;
  wire  rd_w     = avs_read && ack_q && clk_en;
  wire  cr_wr_w  = wr_w && (avs_address == DBGUA_CTRL_OFS);
  wire  thr_wr_w = wr_w && (avs_address == DBGUA_THOLD_OFS);
  wire  rhr_rd_w = rd_w && (avs_address == DBGUA_RHOLD_OFS);
  wire  [31:0] cmd_w = cr_wr_w ? avs_writedata : 32'h0000_0000;
  wire  rx_rst_w   = cmd_w[DBGUA_CR_RX_RESET];
  wire  tx_rst_w   = cmd_w[DBGUA_CR_TX_RESET];
  wire  stat_clr_w = cmd_w[DBGUA_CR_STAT_CLR];
  wire  par_on_w   = !par_sel_q[2];
  wire  tick16_w;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ack_q <= 1'b0;
    else if (clk_en)
      ack_q <= req_w;
  end
  always_comb avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      par_sel_q      <= DBGUA_MODE_RST[2:0];
      baud_divisor_q <= DBGUA_BAUD_RST;
    end
    else if (wr_w && avs_address == DBGUA_MODE_OFS && avs_byteenable[1])
      par_sel_q <= avs_writedata[DBGUA_MR_PAR_LSB +: 3];
    else if (wr_w && avs_address == DBGUA_BAUD_OFS)
      baud_divisor_q <= avs_writedata[15:0];
  end

  // Shared oversample tick for both directions
  dbgua_baud u_baud (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .divisor (baud_divisor_q),
    .tick16  (tick16_w)
  );
  wire tick_w = tick16_w && clk_en;

  // ==========================================================
  // Receiver
  logic [2:0] sync_q;
  logic       rx_en_q;
  logic       rx_stop_q;
  dbgua_rx_t  rx_st_q;
  logic [4:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic [7:0] rx_hold_q;
  logic       rx_rdy_q;
  logic       ovr_q;
  logic       fram_q;
  logic       parity_error_flag_q;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      sync_q <= 3'h7;
    else if (clk_en)
      sync_q <= {sync_q[1:0], serial_in_pin};
  end
  // Stages two and three must agree; absorbs a metastable edge
  wire rxd_lo_w = !sync_q[1] && !sync_q[2];
  wire rx_last_w = rx_bit_q == (par_on_w ? 4'h9 : 4'h8);
  wire rx_smp_w = tick_w && rx_st_q == DBGUA_DATA
                  && rx_cnt_q == 5'h00;
  wire rx_done_w = rx_smp_w && rx_last_w;
  wire par_bad_w = par_on_w &&
                   (par_bit(rx_sh_q[8:1], par_sel_q) != rx_sh_q[0]);

  always_ff @(posedge ref_clk)
  begin
    if (reset || rx_rst_w)
    begin
      rx_en_q   <= 1'b0;
      rx_stop_q <= 1'b0;
      rx_st_q   <= DBGUA_IDLE;
      rx_cnt_q  <= 5'h00;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
    end
    else if (clk_en)
    begin
      if (cmd_w[DBGUA_CR_RX_DIS])
        rx_stop_q <= 1'b1;
      else if (cmd_w[DBGUA_CR_RX_EN])
      begin
        rx_en_q   <= 1'b1;
        rx_stop_q <= 1'b0;
      end
      if (rx_stop_q && rx_st_q == DBGUA_IDLE)
        rx_en_q <= 1'b0;
      case (rx_st_q)
        DBGUA_IDLE:
          if (tick_w && rx_en_q && !rx_stop_q && rxd_lo_w)
          begin
            rx_st_q  <= DBGUA_START;
            rx_cnt_q <= 5'h01;
          end
        DBGUA_START:
          if (tick_w)
          begin
            if (!rxd_lo_w)
              rx_st_q <= DBGUA_IDLE;
            else if (rx_cnt_q == DBGUA_START_MIN)
            begin
              rx_st_q  <= DBGUA_DATA;
              rx_cnt_q <= DBGUA_FIRST_SMP - DBGUA_START_MIN
                          - 5'h02;
              rx_bit_q <= 4'h0;
            end
            else
              rx_cnt_q <= rx_cnt_q + 5'h01;
          end
        DBGUA_DATA:
          if (tick_w)
          begin
            if (rx_cnt_q != 5'h00)
              rx_cnt_q <= rx_cnt_q - 5'h01;
            else
            begin
              rx_cnt_q <= DBGUA_BIT_SMP - 5'h01;
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q < 4'h8)
                rx_sh_q <= {sync_q[2], rx_sh_q[8:1]};
              else if (rx_bit_q == 4'h8 && par_on_w)
                rx_sh_q <= {rx_sh_q[8:1], sync_q[2]};
              if (rx_last_w)
                rx_st_q <= DBGUA_IDLE;
            end
          end
        default: rx_st_q <= DBGUA_IDLE;
      endcase
    end
  end

  // Received data sits in rx_sh_q[8:1] with or without parity
  wire [7:0] rx_data_w = par_on_w ? rx_sh_q[8:1] : rx_sh_q[8:1];
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_hold_q <= 8'h00;
      rx_rdy_q  <= 1'b0;
      ovr_q     <= 1'b0;
      fram_q    <= 1'b0;
      parity_error_flag_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      // Event set wins over simultaneous clear
      rx_rdy_q <= rx_done_w || (rx_rdy_q && !rhr_rd_w);
      if (rx_done_w)
        rx_hold_q <= rx_data_w;
      ovr_q  <= (rx_done_w && rx_rdy_q) || (ovr_q && !stat_clr_w);
      fram_q <= (rx_done_w && !sync_q[2])
                || (fram_q && !stat_clr_w);
      parity_error_flag_q <= (rx_done_w && par_bad_w)
                || (parity_error_flag_q && !stat_clr_w);
    end
  end

  // ==========================================================
  // Transmitter, no guard time between characters
  logic       tx_en_q;
  logic       tx_stop_q;
  logic [7:0] tx_hold_q;
  logic       tx_full_q;
  logic       tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_div_q;
  // Divisor zero must not let a character start and pull the line low
  wire  tx_load_w = tx_en_q && tx_full_q && !tx_busy_q
                    && (baud_divisor_q != 16'h0000);
  wire  tx_bit_end_w = tick_w && tx_busy_q && tx_div_q == DBGUA_OVERSAMPLE;
  always_ff @(posedge ref_clk)
  begin
    if (reset || tx_rst_w)
    begin
      tx_en_q   <= 1'b0;
      tx_stop_q <= 1'b0;
      tx_full_q <= 1'b0;
      tx_hold_q <= 8'h00;
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3ff;
      tx_bits_q <= 4'h0;
      tx_div_q  <= 4'h0;
    end
    else if (clk_en)
    begin
      if (cmd_w[DBGUA_CR_TX_DIS])
        tx_stop_q <= 1'b1;
      else if (cmd_w[DBGUA_CR_TX_EN])
      begin
        tx_en_q   <= 1'b1;
        tx_stop_q <= 1'b0;
      end
      if (tx_stop_q && !tx_busy_q && !tx_full_q)
        tx_en_q <= 1'b0;
      if (thr_wr_w && tx_en_q)
      begin
        tx_hold_q <= avs_writedata[7:0];
        tx_full_q <= 1'b1;
      end
      else if (tx_load_w)
        tx_full_q <= 1'b0;
      if (tx_load_w)
      begin
        tx_busy_q <= 1'b1;
        tx_div_q  <= 4'h0;
        tx_bits_q <= par_on_w ? 4'hb : 4'ha;
        tx_sh_q   <= {par_bit(tx_hold_q, par_sel_q) | !par_on_w,
                      tx_hold_q, 1'b0};
      end
      else if (tick_w && tx_busy_q)
      begin
        tx_div_q <= tx_div_q + 4'h1;
        if (tx_bit_end_w)
        begin
          tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
          if (tx_bits_q == 4'h1)
            tx_busy_q <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      serial_out_pin <= 1'b1;
    else if (clk_en)
      serial_out_pin <= tx_busy_q ? tx_sh_q[0] : 1'b1;
  end

  // ==========================================================
  // Read data mux
  wire [31:0] stat_w = {22'h0,
    tx_en_q && !tx_full_q && !tx_busy_q, 1'b0,
    parity_error_flag_q, fram_q, ovr_q, 3'h0,
    tx_en_q && !tx_full_q, rx_rdy_q};
  wire [31:0] rd_mux_w =
    (avs_address == DBGUA_MODE_OFS)  ? {20'h0, par_sel_q, 9'h0} :
    (avs_address == DBGUA_STAT_OFS)  ? stat_w :
    (avs_address == DBGUA_RHOLD_OFS) ? {24'h0, rx_hold_q} :
    (avs_address == DBGUA_BAUD_OFS)  ? {16'h0, baud_divisor_q} :
                                       32'h0000_0000;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (clk_en && req_w)
      avs_readdata <= avs_read ? rd_mux_w : 32'h0000_0000;
  end

  // ==========================================================
  // Checks
  chk_rx_ready_set: assert property (@(posedge ref_clk) disable iff (reset)
    rx_done_w && clk_en |=> rx_rdy_q)
    else $error("ready not set");
  chk_overrun_set: assert property (@(posedge ref_clk) disable iff (reset)
    rx_done_w && clk_en && rx_rdy_q |=> ovr_q)
    else $error("overrun missed");
  chk_overrun_hold: assert property (@(posedge ref_clk) disable iff (reset)
    ovr_q && !stat_clr_w |=> ovr_q)
    else $error("overrun dropped");
  chk_rx_idle_off: assert property (@(posedge ref_clk) disable iff (reset)
    !rx_en_q |=> rx_st_q == DBGUA_IDLE || $past(rx_st_q) != DBGUA_IDLE)
    else $error("receiver ran while off");
  chk_rx_reset_abort: assert property (@(posedge ref_clk)
    disable iff (reset) rx_rst_w |=> rx_st_q == DBGUA_IDLE && !rx_en_q)
    else $error("rx reset ignored");
  chk_tx_reset_stop: assert property (@(posedge ref_clk)
    disable iff (reset) tx_rst_w |=> !tx_busy_q ##1 serial_out_pin)
    else $error("tx reset ignored");
  chk_tx_idle_high: assert property (@(posedge ref_clk) disable iff (reset)
    !tx_busy_q && clk_en |=> serial_out_pin)
    else $error("line low while idle");
  chk_tx_start_low: assert property (@(posedge ref_clk) disable iff (reset)
    tx_load_w && clk_en |=> tx_busy_q && !tx_sh_q[0])
    else $error("no start bit");
  chk_framing_set: assert property (@(posedge ref_clk) disable iff (reset)
    rx_done_w && clk_en && !sync_q[2] |=> fram_q && rx_rdy_q)
    else $error("framing missed");
  cov_rx_char: cover property (@(posedge ref_clk) rx_done_w);
  cov_tx_char: cover property (@(posedge ref_clk)
    tx_busy_q ##1 !tx_busy_q);
  cov_overrun: cover property (@(posedge ref_clk) ovr_q);
endmodule : dbgua_top
`default_nettype wire

// ==== dbgua_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbgua_top_tb
  import dbgua_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_in_pin;
  logic        serial_out_pin;
  int          bad_count = 0;
  int          n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  dbgua_top dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin));
  dbgua_host #(.BIT_CLKS(16)) host_u (.ref_clk(ref_clk),
    .line_in(serial_out_pin), .line_out(serial_in_pin));
  // ==========================================================
  // Reporting
  task automatic complete_run;
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic fail(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail
  task automatic check(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    n_tests++;
    if (g !== e)
      fail(m);
  endtask : check
  // ==========================================================
  // Avalon master; holds the request until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50)
    begin
      fail("bus timeout");
      complete_run();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(rd, e, "register read");
  endtask : rdc
  task automatic cmd(input int b);
    wr(DBGUA_CTRL_OFS, 32'h1 << b);
  endtask : cmd
  task automatic sts(input int b, input logic e);
    logic [31:0] rd;
    bus(1'b0, DBGUA_STAT_OFS, 32'h0, rd);
    check(32'(rd[b]), 32'(e), "status bit");
  endtask : sts
  task automatic quiet(input int n);
    int lows;
    lows = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      if (serial_out_pin !== 1'b1)
        lows++;
    end
    check(lows, 0, "line not idle");
  endtask : quiet
  function automatic logic pbit(input logic [7:0] d, input logic [2:0] m);
    case (m)
      DBGUA_PAR_EVEN: return ^d;
      DBGUA_PAR_ODD: return ~^d;
      DBGUA_PAR_SPACE: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction : pbit
  task automatic txc(input logic [7:0] d, input logic [2:0] m);
    logic [7:0] g;
    logic       p;
    logic       s;
    logic       seen;
    int         ll;
    host_u.capture(!m[2], g, p, s, ll, seen);
    if (!seen)
    begin
      fail("no frame");
      complete_run();
    end
    check(32'(g), 32'(d), "tx data");
    check(ll, 16, "bit time");
    check(32'(s), 32'h1, "tx stop");
    if (!m[2])
      check(32'(p), 32'(pbit(d, m)), "tx parity");
  endtask : txc
  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fail("run timeout");
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [2:0] modes [5];
    modes = '{DBGUA_PAR_EVEN, DBGUA_PAR_ODD, DBGUA_PAR_SPACE,
              DBGUA_PAR_MARK, 3'h4};
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(DBGUA_MODE_OFS, 32'h0);
    rdc(DBGUA_BAUD_OFS, 32'h0);
    rdc(8'h30, 32'h0);
    sts(DBGUA_SR_TX_FREE, 1'b0);
    wr(DBGUA_BAUD_OFS, 32'h0000ffff);
    rdc(DBGUA_BAUD_OFS, 32'h0000ffff);
    wr(DBGUA_BAUD_OFS, 32'h0);
    cmd(DBGUA_CR_TX_EN);
    wr(DBGUA_THOLD_OFS, 32'h55);
    quiet(300);
    cmd(DBGUA_CR_TX_RESET);
    wr(DBGUA_BAUD_OFS, 32'h1);
    quiet(300);
    cmd(DBGUA_CR_TX_EN);
    sts(DBGUA_SR_TX_FREE, 1'b1);
    foreach (modes[i])
    begin
      wr(DBGUA_MODE_OFS, 32'(modes[i]) << DBGUA_MR_PAR_LSB);
      fork
        wr(DBGUA_THOLD_OFS, 32'hb5);
        txc(8'hb5, modes[i]);
      join
    end
    repeat (16) @(posedge ref_clk);
    sts(DBGUA_SR_TX_DONE, 1'b1);
    wr(DBGUA_MODE_OFS, 32'h0);
    fork
      begin
        txc(8'h3b, DBGUA_PAR_EVEN);
        txc(8'hc7, DBGUA_PAR_EVEN);
      end
      begin
        wr(DBGUA_THOLD_OFS, 32'h3b);
        wr(DBGUA_THOLD_OFS, 32'hc7);
        sts(DBGUA_SR_TX_FREE, 1'b0);
        sts(DBGUA_SR_TX_DONE, 1'b0);
        cmd(DBGUA_CR_TX_DIS);
      end
    join
    repeat (16) @(posedge ref_clk);
    wr(DBGUA_THOLD_OFS, 32'h99);
    quiet(300);
    cmd(DBGUA_CR_TX_EN);
    wr(DBGUA_THOLD_OFS, 32'hf1);
    repeat (40) @(posedge ref_clk);
    cmd(DBGUA_CR_TX_RESET);
    repeat (2) @(posedge ref_clk);
    quiet(300);
    host_u.send(8'h3c, 1'b1, ^8'h3c, 1'b1);
    sts(DBGUA_SR_RX_RDY, 1'b0);
    cmd(DBGUA_CR_RX_EN);
    host_u.send(8'h3c, 1'b1, ^8'h3c, 1'b1);
    sts(DBGUA_SR_RX_RDY, 1'b1);
    rdc(DBGUA_RHOLD_OFS, 32'h3c);
    sts(DBGUA_SR_RX_RDY, 1'b0);
    host_u.pulse_low(7);
    repeat (200) @(posedge ref_clk);
    sts(DBGUA_SR_RX_RDY, 1'b0);
    host_u.send(8'h81, 1'b1, 1'b1, 1'b1);
    sts(DBGUA_SR_PAR_ERR, 1'b1);
    rdc(DBGUA_RHOLD_OFS, 32'h81);
    host_u.send(8'h42, 1'b1, 1'b0, 1'b0);
    sts(DBGUA_SR_FRAMING, 1'b1);
    rdc(DBGUA_RHOLD_OFS, 32'h42);
    host_u.send(8'h11, 1'b1, 1'b0, 1'b1);
    host_u.send(8'h22, 1'b1, 1'b0, 1'b1);
    sts(DBGUA_SR_OVERRUN, 1'b1);
    sts(DBGUA_SR_PAR_ERR, 1'b1);
    rdc(DBGUA_RHOLD_OFS, 32'h22);
    cmd(DBGUA_CR_STAT_CLR);
    sts(DBGUA_SR_OVERRUN, 1'b0);
    sts(DBGUA_SR_PAR_ERR, 1'b0);
    sts(DBGUA_SR_FRAMING, 1'b0);
    fork
      host_u.send(8'h5a, 1'b1, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge ref_clk);
        cmd(DBGUA_CR_RX_RESET);
      end
    join
    sts(DBGUA_SR_RX_RDY, 1'b0);
    cmd(DBGUA_CR_RX_EN);
    fork
      host_u.send(8'h6b, 1'b1, 1'b1, 1'b1);
      begin
        repeat (60) @(posedge ref_clk);
        cmd(DBGUA_CR_RX_DIS);
      end
    join
    rdc(DBGUA_RHOLD_OFS, 32'h6b);
    host_u.send(8'h77, 1'b1, 1'b0, 1'b1);
    sts(DBGUA_SR_RX_RDY, 1'b0);
    complete_run();
  end
endmodule : dbgua_top_tb
`default_nettype wire
